// ==== rtl/csb_map.vh ====
`ifndef CSB_MAP_VH
`define CSB_MAP_VH
// Control port map
`define CTRL_ADDR 7'h01
`define STAT_ADDR 7'h02
`define EBUF_BASE 7'h20
`define EBUF_LAST 7'h37
`define UBUF_BASE 7'h40
`define UBUF_LAST 7'h6f
// Control register bits
`define C_INH_DE 0
`define C_INH_EF 1
`define C_RSV 2
`define C_TWOBYTE 3
`define C_RDSEL_B 4
`define C_IE_DE 5
`define C_IE_EF 6
`define CTRL_RST 8'h00
// Status register bits
`define S_DE 0
`define S_EF 1
// Write entry kinds
`define WK_BOTH 2'h0
`define WK_A 2'h1
`define WK_B 2'h2
// Block layout
`define BLK_BYTES 48
`define BLK_LASTBIT 8'hbf
`define RSV_BYTES 5
`define CRC_IDX 23
`define CRC_INIT 8'hff
`define CRC_POLY 8'h1d
`endif

// ==== rtl/wr_fifo.v ====
`timescale 1ns/1ps
module wr_fifo #(
   parameter W = 17,
   parameter D = 16,
   parameter AW = 4
) (
   input wire clk,
   input wire rst_n,
   input wire in_valid,
   input wire [W-1:0] in_data,
   output reg in_ready,
   output wire out_valid,
   output wire [W-1:0] out_data,
   input wire out_ready
);
   reg [W-1:0] mem [0:D-1];
   reg [AW-1:0] wp_r;
   reg [AW-1:0] rp_r;
   reg [AW:0] cnt_r;
   reg [AW:0] cnt_nxt;
   wire push = in_valid & in_ready;
   wire pop = out_valid & out_ready;
   assign out_valid = (cnt_r != {(AW+1){1'b0}});
   assign out_data = mem[rp_r];
   always @* begin
      cnt_nxt = cnt_r;
      if (push & ~pop)
         cnt_nxt = cnt_r + 1'b1;
      else if (pop & ~push)
         cnt_nxt = cnt_r - 1'b1;
   end
   always @(posedge clk) begin
      if (push)
         mem[wp_r] <= in_data;
   end
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wp_r <= {AW{1'b0}};
         rp_r <= {AW{1'b0}};
         cnt_r <= {(AW+1){1'b0}};
         in_ready <= 1'b0;
      end else begin
         if (push)
            wp_r <= wp_r + 1'b1;
         if (pop)
            rp_r <= rp_r + 1'b1;
         cnt_r <= cnt_nxt;
         in_ready <= (cnt_nxt != D[AW:0]);
      end
   end
endmodule

// ==== rtl/cs_block_buffer.v ====
`timescale 1ns/1ps
`include "csb_map.vh"
// Summary of operation
// (R1) Holds one channel-status block per channel, 384 bits, host RW.
// (R2) Holds 384 bits of user-bit storage, host RW.
// (R3) Status moves only as whole blocks through three block buffers.
// (R4) Byte MSB holds earliest serial bit; later bits go lower.
// (R5) Middle buffer byte zero sits at address 20h, channel A first.
// (R6) First buffer assembles received bits until a block is complete.
// (R7) Middle buffer takes whole blocks from first, stays host RW.
// (R8) Third buffer takes whole blocks from middle, sole transmit source.
// (R9) First-to-middle on input timing, middle-to-third on output timing.
// (R10) Slow input repeats blocks; fast input drops surplus blocks.
// (R11) Enabled interrupt on each first-to-middle and middle-to-third move.
// (R12) Two host inhibit bits each block their transfer while set.
// (R13) Host inhibits first-to-middle when serial audio feeds the output.
// (R14) Host reads middle buffer just after a first-to-middle interrupt.
// (R15) Host writes after middle-to-third, inhibiting first-to-middle meanwhile.
// (R16) Professional blocks get their check byte computed and inserted.
// (R17) Reserve option keeps first 5 middle bytes from transfers.
// (R18) Host rewrites sample-count bits per block if it cares.
// (R19) Middle buffer is 24 words; high byte channel A, low B.
// (R20) One-byte mode writes both channels; read picks channel by bit.
// (R21) Two-byte mode reads and writes channel A byte then B.
// (R22) Each stage transfer is atomic; no block mixing.
// (R23) Host access coinciding with a transfer corrupts nothing.
module cs_block_buffer #(
   parameter FIFO_DEPTH = 16,
   parameter FIFO_AW = 4
) (
   input wire clk,
   input wire rst_n,
   input wire rx_bit_valid,
   input wire rx_ch_b,
   input wire rx_bit,
   input wire rx_block_start,
   input wire tx_bit_req,
   input wire tx_ch_b,
   input wire tx_block_start,
   output reg tx_cbit,
   input wire [6:0] host_addr,
   input wire host_wr,
   input wire [7:0] host_wdata,
   output wire host_wready,
   input wire host_rd,
   output reg [7:0] host_rdata,
   output reg host_rvalid,
   output reg irq
);
   reg [7:0] d_mem [0:`BLK_BYTES-1];
   reg [7:0] e_mem [0:`BLK_BYTES-1];
   reg [7:0] f_mem [0:`BLK_BYTES-1];
   reg [7:0] u_mem [0:`BLK_BYTES-1];
   reg [7:0] rx_sh [0:1];
   reg [7:0] rx_cnt [0:1];
   reg [7:0] tx_cnt [0:1];
   reg [7:0] ctrl_r;
   reg [1:0] stat_r;
   reg d_done_r;
   reg phase_b_r;
   integer i;

   function [7:0] crc_step;
      input [7:0] crc;
      input [7:0] data;
      integer k;
      reg [7:0] c;
      begin
         c = crc;
         for (k = 7; k >= 0; k = k - 1) begin
            if (c[7] ^ data[k])
               c = {c[6:0], 1'b0} ^ `CRC_POLY;
            else
               c = {c[6:0], 1'b0};
         end
         crc_step = c;
      end
   endfunction

   function [7:0] crc_blk;
      input ch;
      integer j;
      reg [7:0] c;
      begin
         c = `CRC_INIT;
         for (j = 0; j < `CRC_IDX; j = j + 1)
            c = crc_step(c, e_mem[j*2 + ch]);
         crc_blk = c;
      end
   endfunction

   // Per-channel E index for a word address
   function [5:0] e_idx;
      input [6:0] a;
      input b;
      reg [6:0] w;
      begin
         w = a - `EBUF_BASE;
         e_idx = {w[4:0], b};
      end
   endfunction

   wire is_e = (host_addr >= `EBUF_BASE) && (host_addr <= `EBUF_LAST);
   wire two_byte = ctrl_r[`C_TWOBYTE];
   wire do_de = d_done_r & ~ctrl_r[`C_INH_DE];
   wire do_ef = tx_block_start & ~ctrl_r[`C_INH_EF];

   // Host writes queue until no transfer owns the middle buffer
   wire [1:0] wr_kind = !(is_e && two_byte) ? `WK_BOTH :
                        (phase_b_r ? `WK_B : `WK_A);
   wire q_valid;
   wire [16:0] q_data;
   wire q_pop = q_valid & ~do_de & ~do_ef; // [R23]
   wire [6:0] q_addr = q_data[16:10];
   wire [1:0] q_kind = q_data[9:8];
   wire [7:0] q_byte = q_data[7:0];
   wire q_is_e = (q_addr >= `EBUF_BASE) && (q_addr <= `EBUF_LAST);
   wire q_is_u = (q_addr >= `UBUF_BASE) && (q_addr <= `UBUF_LAST);
   wire [6:0] q_uoff = q_addr - `UBUF_BASE;
   wire [6:0] h_uoff = host_addr - `UBUF_BASE;
   wire host_acc_ok = host_wr & host_wready;

   wr_fifo #(
      .W(17),
      .D(FIFO_DEPTH),
      .AW(FIFO_AW)
   ) u_wq (
      .clk(clk),
      .rst_n(rst_n),
      .in_valid(host_wr),
      .in_data({host_addr, wr_kind, host_wdata}),
      .in_ready(host_wready),
      .out_valid(q_valid),
      .out_data(q_data),
      .out_ready(q_pop)
   );

   // Two-byte sequencing: A byte then B byte per word
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         phase_b_r <= 1'b0;
      end else if (host_acc_ok || host_rd) begin
         if (is_e && two_byte)
            phase_b_r <= ~phase_b_r; // [R21]
         else
            phase_b_r <= 1'b0;
      end
   end

   // Receive assembly into first buffer
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_sh[0] <= 8'h00;
         rx_sh[1] <= 8'h00;
         rx_cnt[0] <= 8'h00;
         rx_cnt[1] <= 8'h00;
         d_done_r <= 1'b0;
      end else begin
         d_done_r <= 1'b0;
         if (rx_bit_valid) begin
            rx_sh[rx_ch_b] <= {rx_sh[rx_ch_b][6:0], rx_bit}; // [R4]
            if (rx_block_start)
               rx_cnt[rx_ch_b] <= 8'h01;
            else if (rx_cnt[rx_ch_b] == `BLK_LASTBIT)
               rx_cnt[rx_ch_b] <= 8'h00;
            else
               rx_cnt[rx_ch_b] <= rx_cnt[rx_ch_b] + 8'h01;
            if (rx_block_start)
               rx_sh[rx_ch_b] <= {7'h00, rx_bit};
            // Block done when channel B delivers its last bit
            if (rx_ch_b && !rx_block_start &&
                rx_cnt[1] == `BLK_LASTBIT)
               d_done_r <= 1'b1; // [R6]
         end
      end
   end

   always @(posedge clk) begin
      if (rx_bit_valid && !rx_block_start &&
          rx_cnt[rx_ch_b][2:0] == 3'h7)
         d_mem[{rx_cnt[rx_ch_b][7:3], rx_ch_b}] <=
            {rx_sh[rx_ch_b][6:0], rx_bit}; // [R4] [R6]
   end

   // Middle buffer: whole-block loads or one queued host write
   always @(posedge clk) begin
      if (do_de) begin
         for (i = 0; i < `BLK_BYTES; i = i + 1)
            if (!(ctrl_r[`C_RSV] && (i / 2) < `RSV_BYTES)) // [R17]
               e_mem[i] <= d_mem[i]; // [R7] [R9] [R22] [R10]
      end else if (q_pop && q_is_e) begin
         if (q_kind != `WK_B)
            e_mem[e_idx(q_addr, 1'b0)] <= q_byte; // [R5] [R19]
         if (q_kind != `WK_A)
            e_mem[e_idx(q_addr, 1'b1)] <= q_byte; // [R20] [R21]
      end
   end

   // User-bit storage, host access only
   always @(posedge clk) begin
      if (q_pop && q_is_u)
         u_mem[q_uoff[5:0]] <= q_byte; // [R2]
   end

   // Third buffer: whole-block load with check byte insertion
   always @(posedge clk) begin
      if (do_ef) begin
         for (i = 0; i < `BLK_BYTES; i = i + 1)
            f_mem[i] <= e_mem[i]; // [R8] [R9] [R22] [R3]
         if (e_mem[0][7])
            f_mem[`CRC_IDX*2] <= crc_blk(1'b0); // [R16]
         if (e_mem[1][7])
            f_mem[`CRC_IDX*2+1] <= crc_blk(1'b1); // [R16]
      end
   end

   // Transmit bit stream, repeating third buffer each block
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_cnt[0] <= 8'h00;
         tx_cnt[1] <= 8'h00;
         tx_cbit <= 1'b0;
      end else begin
         if (tx_block_start) begin
            tx_cnt[0] <= 8'h00;
            tx_cnt[1] <= 8'h00;
         end else if (tx_bit_req) begin
            tx_cbit <= f_mem[{tx_cnt[tx_ch_b][7:3], tx_ch_b}]
                       [3'h7 - tx_cnt[tx_ch_b][2:0]]; // [R8] [R4]
            if (tx_cnt[tx_ch_b] == `BLK_LASTBIT)
               tx_cnt[tx_ch_b] <= 8'h00; // [R10]
            else
               tx_cnt[tx_ch_b] <= tx_cnt[tx_ch_b] + 8'h01;
         end
      end
   end

   // Control, sticky transfer flags, interrupt, host reads
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_r <= `CTRL_RST;
         stat_r <= 2'h0;
         irq <= 1'b0;
         host_rdata <= 8'h00;
         host_rvalid <= 1'b0;
      end else begin
         if (q_pop && q_addr == `CTRL_ADDR)
            ctrl_r <= q_byte; // [R12]
         irq <= (do_de & ctrl_r[`C_IE_DE]) |
                (do_ef & ctrl_r[`C_IE_EF]); // [R11]
         host_rvalid <= host_rd;
         if (host_rd && host_addr == `STAT_ADDR)
            stat_r <= {do_ef, do_de};
         else
            stat_r <= stat_r | {do_ef, do_de};
         if (host_rd) begin
            if (host_addr == `CTRL_ADDR)
               host_rdata <= ctrl_r;
            else if (host_addr == `STAT_ADDR)
               host_rdata <= {6'h00, stat_r};
            else if (is_e)
               host_rdata <= e_mem[e_idx(host_addr,
                  two_byte ? phase_b_r : ctrl_r[`C_RDSEL_B])]; // [R1] [R20]
            else if ((host_addr >= `UBUF_BASE) &&
                     (host_addr <= `UBUF_LAST))
               host_rdata <= u_mem[h_uoff[5:0]]; // [R2]
            else
               host_rdata <= 8'h00;
         end
      end
   end
endmodule

// ==== verif/cs_block_buffer_sva.sv ====
`timescale 1ns/1ps
module cs_block_buffer_sva (
   input wire clk,
   input wire rst_n,
   input wire rx_bit_valid,
   input wire rx_ch_b,
   input wire rx_block_start,
   input wire tx_block_start,
   input wire [6:0] host_addr,
   input wire host_wr,
   input wire [7:0] host_wdata,
   input wire host_wready,
   input wire host_rd,
   input wire [7:0] host_rdata,
   input wire host_rvalid,
   input wire irq
);
   reg [7:0] ctrl_r;
   reg [7:0] bcnt_r;
   wire done;
   // Last channel B bit of a block
   assign done = rx_bit_valid && rx_ch_b && !rx_block_start &&
      bcnt_r == 8'hbf;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_r <= 8'h00;
         bcnt_r <= 8'h00;
      end else begin
         if (host_wr && host_wready && host_addr == 7'h01)
            ctrl_r <= host_wdata;
         if (rx_bit_valid && rx_ch_b)
            bcnt_r <= rx_block_start ? 8'h01 : bcnt_r + 8'h01;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   chk_read_answer: assert property (host_rd |=> host_rvalid)
      else $error("read not answered");
   chk_read_cause: assert property (host_rvalid |-> $past(host_rd))
      else $error("answer without read");
   chk_unmapped_zero: assert property (host_rd && host_addr == 7'h7f
      |=> host_rdata == 8'h00)
      else $error("unmapped read not zero");
   chk_rx_irq: assert property (done && ctrl_r[5] && !ctrl_r[0]
      |-> ##2 irq)
      else $error("no irq after block");
   chk_rx_inhibit: assert property (done && ctrl_r[0] ##1 !tx_block_start
      |=> !irq)
      else $error("irq on inhibited move");
   chk_tx_irq: assert property (tx_block_start && ctrl_r[6] && !ctrl_r[1]
      |=> irq)
      else $error("no irq on output move");
   chk_tx_inhibit: assert property (tx_block_start && ctrl_r[1] &&
      !$past(rx_bit_valid) |=> !irq)
      else $error("irq on inhibited output move");
   chk_irq_enabled: assert property (irq |-> ctrl_r[5] || ctrl_r[6])
      else $error("irq while disabled");
   cover property (done ##2 irq);
   cover property (tx_block_start && ctrl_r[1]);
   cover property (host_rvalid);
endmodule
bind cs_block_buffer cs_block_buffer_sva i_chk (.clk(clk), .rst_n(rst_n),
   .rx_bit_valid(rx_bit_valid), .rx_ch_b(rx_ch_b),
   .rx_block_start(rx_block_start), .tx_block_start(tx_block_start),
   .host_addr(host_addr), .host_wr(host_wr), .host_wdata(host_wdata),
   .host_wready(host_wready), .host_rd(host_rd),
   .host_rdata(host_rdata), .host_rvalid(host_rvalid), .irq(irq));

// ==== verif/host_model.sv ====
`timescale 1ns/1ps
module host_model (
   input wire clk,
   input wire host_wready,
   input wire [7:0] host_rdata,
   output reg [6:0] host_addr,
   output reg host_wr,
   output reg [7:0] host_wdata,
   output reg host_rd
);
   initial begin
      host_addr = 7'h00;
      host_wr = 1'b0;
      host_wdata = 8'h00;
      host_rd = 1'b0;
   end
   // Idle bus shows inverted values, never the last ones
   task wr(input [6:0] a, input [7:0] d);
      begin
         @(negedge clk);
         host_addr = a;
         host_wdata = d;
         host_wr = 1'b1;
         while (!host_wready) @(negedge clk);
         @(negedge clk);
         host_wr = 1'b0;
         host_addr = ~a;
         host_wdata = ~d;
      end
   endtask
   // Gap lets queued writes land first
   task rd(input [6:0] a, output [7:0] d);
      begin
         repeat (2) @(negedge clk);
         host_addr = a;
         host_rd = 1'b1;
         @(negedge clk);
         host_rd = 1'b0;
         host_addr = ~a;
         @(posedge clk);
         #1 d = host_rdata;
      end
   endtask
endmodule

// ==== verif/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
   reg clk, rst_n, rx_bit_valid, rx_ch_b, rx_bit, rx_block_start;
   reg tx_bit_req, tx_ch_b, tx_block_start;
   wire tx_cbit, host_wready, host_rvalid, irq, host_wr, host_rd;
   wire [6:0] host_addr;
   wire [7:0] host_wdata, host_rdata;
   integer fail_count, checked;
   cs_block_buffer i_cs_block_buffer (.clk(clk), .rst_n(rst_n),
      .rx_bit_valid(rx_bit_valid), .rx_ch_b(rx_ch_b), .rx_bit(rx_bit),
      .rx_block_start(rx_block_start), .tx_bit_req(tx_bit_req),
      .tx_ch_b(tx_ch_b), .tx_block_start(tx_block_start),
      .tx_cbit(tx_cbit), .host_addr(host_addr), .host_wr(host_wr),
      .host_wdata(host_wdata), .host_wready(host_wready),
      .host_rd(host_rd), .host_rdata(host_rdata),
      .host_rvalid(host_rvalid), .irq(irq));
   host_model i_host_model (.clk(clk), .host_wready(host_wready),
      .host_rdata(host_rdata), .host_addr(host_addr), .host_wr(host_wr),
      .host_wdata(host_wdata), .host_rd(host_rd));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   function [7:0] pat(input ch, input [4:0] k);
      pat = ch ? 8'h40 + k : 8'h01 + k;
   endfunction
   task chk(input [23:0] s, input [23:0] e);
      begin
         checked = checked + 1;
         if (s !== e) begin
            fail_count = fail_count + 1;
            $display("unexpected at %0t: got %h want %h", $time, s, e);
         end
      end
   endtask
   task wr(input [6:0] a, input [7:0] d);
      i_host_model.wr(a, d);
   endtask
   task rdc(input [6:0] a, input [7:0] e);
      reg [7:0] d;
      begin
         i_host_model.rd(a, d);
         chk({16'h0000, d}, {16'h0000, e});
      end
   endtask
   // Channels interleave, MSB of each byte first
   task rx_block;
      integer i, c;
      reg [7:0] b;
      begin
         for (i = 0; i < 384; i = i + 1) begin
            c = i % 2;
            b = pat(c[0], i[8:4]);
            @(negedge clk);
            rx_bit_valid = 1'b1;
            rx_ch_b = c[0];
            rx_block_start = (i < 2);
            rx_bit = b[7 - (i / 2) % 8];
         end
         @(negedge clk);
         rx_bit_valid = 1'b0;
      end
   endtask
   task tx_start(input e);
      begin
         @(negedge clk);
         tx_block_start = 1'b1;
         // Irq pulse stands only in the cycle after the start edge
         @(posedge clk);
         #1 chk({23'h0, irq}, {23'h0, e});
         @(negedge clk);
         tx_block_start = 1'b0;
      end
   endtask
   task tx_chk(input ch, input [23:0] e);
      integer k;
      reg [23:0] got;
      begin
         for (k = 0; k <= 24; k = k + 1) begin
            @(negedge clk);
            if (k > 0)
               got = {got[22:0], tx_cbit};
            tx_bit_req = (k < 24);
            tx_ch_b = ch;
         end
         chk(got, e);
      end
   endtask
   task t_rx;
      begin
         rdc(7'h7f, 8'h00);
         wr(7'h01, 8'h20);
         rx_block;
         @(posedge clk);
         #1 chk({23'h0, irq}, 24'h1);
         rdc(7'h02, 8'h01);
         rdc(7'h20, pat(1'b0, 5'd0));
         rdc(7'h37, pat(1'b0, 5'd23));
         wr(7'h01, 8'h30);
         rdc(7'h20, pat(1'b1, 5'd0));
         $display("rx test done");
      end
   endtask
   task t_rsv;
      begin
         wr(7'h01, 8'h04);
         wr(7'h20, 8'h99);
         wr(7'h25, 8'h00);
         rx_block;
         rdc(7'h20, 8'h99);
         rdc(7'h25, pat(1'b0, 5'd5));
         $display("reserve test done");
      end
   endtask
   task t_inh;
      begin
         wr(7'h01, 8'h01);
         wr(7'h21, 8'hc3);
         rx_block;
         rdc(7'h21, 8'hc3);
         wr(7'h01, 8'h11);
         rdc(7'h21, 8'hc3);
         $display("inhibit test done");
      end
   endtask
   task t_two;
      begin
         wr(7'h01, 8'h09);
         wr(7'h22, 8'h5a);
         wr(7'h22, 8'ha5);
         rdc(7'h22, 8'h5a);
         rdc(7'h22, 8'ha5);
         $display("two byte test done");
      end
   endtask
   task t_tx;
      begin
         wr(7'h01, 8'h41);
         tx_start(1'b1);
         tx_chk(1'b0, 24'h99c35a);
         tx_chk(1'b1, 24'h99c3a5);
         wr(7'h01, 8'h03);
         wr(7'h20, 8'h11);
         tx_start(1'b0);
         tx_chk(1'b0, 24'h99c35a);
         $display("tx test done");
      end
   endtask
   task results;
      begin
         $display("checks %0d mismatches %0d", checked, fail_count);
         if (fail_count == 0 && checked > 0)
            $display("Test passed");
         else
            $display("Test failed");
         $finish;
      end
   endtask
   initial begin
      rst_n = 1'b0;
      {rx_bit_valid, rx_ch_b, rx_bit, rx_block_start} = 4'h0;
      {tx_bit_req, tx_ch_b, tx_block_start} = 3'h0;
      fail_count = 0;
      checked = 0;
      repeat (3) @(posedge clk);
      @(negedge clk);
      rst_n = 1'b1;
      t_rx;
      t_rsv;
      t_inh;
      t_two;
      t_tx;
      results;
   end
   // Tests need about 7 us
   initial begin
      #60000;
      fail_count = fail_count + 1;
      results;
   end
endmodule
